// >>> logic/sdsd_cmp.v
`timescale 1ns/1ns
// registered unsigned compare: flag when value exceeds threshold
module sdsd_cmp #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] value,
  input  wire [W-1:0] thresh,
  output reg          above_q
);
  always @(posedge clk) begin
    if (rst) begin
      above_q <= 1'b0;
    end else begin
      above_q <= (value > thresh);
    end
  end
endmodule // sdsd_cmp

// >>> logic/sdsd_setup_decode.v
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "sdsd_regs.vh"
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - bit 0 clear: servo follows run input; set: servo always on
// - bit 1 set: sensor-on input treated as high internally
// - bit 2 clear honours forward prohibit; set permits; factory one
// - bit 3 clear honours reverse prohibit; set permits; factory one
// - bit 4 picks status output: rotation detected or current limit
// - power-stop recovery: bit 5 clear latches alarm, set auto-clears
// - abnormal stop: bit 6 clear dynamic brake, set free run
// - bit 7 keeps dynamic brake engaged after stop when set
// - bit 6 one and bit 8 zero: brake released after stop
// - overtravel: bit 8 clear uses bit 6 method, set uses estop torque
// - after overtravel stop: bit 9 clear servo off, set position lock
// - bits 11:10 select speed, speed lock, torque one, torque two
// - bits 13:12 select p switch condition; factory no switching
// - p switching only acts in speed control modes
// - torque modes: stop method from bit 6 only, bit 8 ignored
// - bit 14 declares absolute encoder; host sets it for such motors
// - bit 15 enables torque feed-forward
// - written setup takes effect only after a full power cycle
// - torque mode over speed limit yields proportional retard torque
// - word two bit 2 set reinterprets bits 11:10 as speed select
// - torque threshold for p switching in percent, factory 200
// - rotation detect threshold in r/min, factory 20
module sdsd_setup_decode #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  // register port
  input  wire [3:0]   reg_addr,
  input  wire [15:0]  reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [15:0]  reg_rdata_q,
  // sequence inputs
  input  wire         run_in,
  input  wire         sensor_on_in,
  input  wire         forward_prohibit_input,
  input  wire         reverse_prohibit_input,
  input  wire         power_good,
  input  wire         abnormal_stop,
  // motor feedback and command sources
  input  wire [W-1:0] motor_speed,
  input  wire [W-1:0] speed_cmd,
  input  wire [W-1:0] torque_cmd,
  input  wire [W-1:0] accel_cmd,
  input  wire         current_limit_hit,
  input  wire         motor_stopped,
  // outputs
  output reg          servo_on_q,
  output reg          sensor_on_q,
  output reg          fwd_enable_q,
  output reg          rev_enable_q,
  output reg          rotation_or_limit_status_out,
  output reg          servo_alarm_q,
  output reg          dyn_brake_q,
  output reg          free_run_q,
  output reg          estop_torque_en_q,
  output reg  [W-1:0] estop_torque_q,
  output reg          pos_lock_q,
  output reg  [1:0]   ctrl_mode_q,
  output reg  [1:0]   int_speed_sel_q,
  output reg          p_control_q,
  output reg          absolute_encoder_select,
  output reg          torque_ff_en_q,
  output reg  [W-1:0] retard_torque_q
);
  localparam [1:0] MODE_SPEED = 2'h0;
  localparam [1:0] MODE_LOCK  = 2'h1;
  localparam [1:0] MODE_TRQ1  = 2'h2;
  localparam [1:0] MODE_TRQ2  = 2'h3;
  localparam [1:0] PSW_TRQ    = 2'h0;
  localparam [1:0] PSW_SPD    = 2'h1;
  localparam [1:0] PSW_ACC    = 2'h2;
  // one-hot power sequence states
  localparam [2:0] ST_OFF = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_DIP = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // software-visible pending values and power-up snapshot
  reg [15:0]  drive_setup_word_one;     // pending, as written
  reg [15:0]  drive_setup_word_two;
  reg [15:0]  act_one_q;                // applied copy
  reg [15:0]  act_two_q;
  reg [W-1:0] emergency_stop_torque_param;
  reg [W-1:0] pswitch_torque_threshold;
  reg [W-1:0] pswitch_speed_threshold;
  reg [W-1:0] pswitch_accel_threshold;
  reg [W-1:0] rotation_detect_speed;
  reg [W-1:0] speed_limit_q;
  reg [2:0]   state_q;
  reg [3:0]   pwr_cnt_q;
  reg         ot_stop_q;

  wire rot_above;
  wire trq_above;
  wire spd_above;
  wire acc_above;
  wire [W-1:0] retard;

  // decoded fields of the applied word
  wire [1:0] mode_f  = {act_one_q[`SDSD_B_MODE_HI],
                        act_one_q[`SDSD_B_MODE_LO]};
  wire [1:0] psw_f   = {act_one_q[`SDSD_B_PSW_HI], act_one_q[`SDSD_B_PSW_LO]};
  wire       int_spd = act_two_q[`SDSD_B2_INT_SPEED];
  // with internal speed selected the field is a speed select, mode is speed
  wire [1:0] eff_mode = int_spd ? MODE_SPEED : mode_f;
  wire       torque_mode = (eff_mode == MODE_TRQ1) || (eff_mode == MODE_TRQ2);
  wire       ot_hit = (forward_prohibit_input &&
                       !act_one_q[`SDSD_B_FWD_PERMIT]) ||
                      (reverse_prohibit_input &&
                       !act_one_q[`SDSD_B_REV_PERMIT]);

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge clk) begin
    if (rst) begin
      drive_setup_word_one        <= `SDSD_RST_SETUP_ONE;
      drive_setup_word_two        <= `SDSD_RST_SETUP_TWO;
      emergency_stop_torque_param <= `SDSD_RST_ESTOP_TRQ;
      pswitch_torque_threshold    <= `SDSD_RST_PSW_TRQ;
      pswitch_speed_threshold     <= {W{1'b0}};
      pswitch_accel_threshold     <= {W{1'b0}};
      rotation_detect_speed       <= `SDSD_RST_ROT_SPD;
      speed_limit_q               <= `SDSD_RST_SPD_LIMIT;
    end else if (reg_wr) begin
      case (reg_addr)
        `SDSD_ADDR_SETUP_ONE: drive_setup_word_one        <= reg_wdata;
        `SDSD_ADDR_SETUP_TWO: drive_setup_word_two        <= reg_wdata;
        `SDSD_ADDR_ESTOP_TRQ: emergency_stop_torque_param <= reg_wdata;
        `SDSD_ADDR_PSW_TRQ:   pswitch_torque_threshold    <= reg_wdata;
        `SDSD_ADDR_PSW_SPD:   pswitch_speed_threshold     <= reg_wdata;
        `SDSD_ADDR_PSW_ACC:   pswitch_accel_threshold     <= reg_wdata;
        `SDSD_ADDR_ROT_SPD:   rotation_detect_speed       <= reg_wdata;
        `SDSD_ADDR_SPD_LIMIT: speed_limit_q               <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SDSD_ADDR_SETUP_ONE:  reg_rdata_q <= drive_setup_word_one;
        `SDSD_ADDR_SETUP_TWO:  reg_rdata_q <= drive_setup_word_two;
        `SDSD_ADDR_ACTIVE_ONE: reg_rdata_q <= act_one_q;
        `SDSD_ADDR_ACTIVE_TWO: reg_rdata_q <= act_two_q;
        `SDSD_ADDR_ESTOP_TRQ:  reg_rdata_q <= emergency_stop_torque_param;
        `SDSD_ADDR_PSW_TRQ:    reg_rdata_q <= pswitch_torque_threshold;
        `SDSD_ADDR_PSW_SPD:    reg_rdata_q <= pswitch_speed_threshold;
        `SDSD_ADDR_PSW_ACC:    reg_rdata_q <= pswitch_accel_threshold;
        `SDSD_ADDR_ROT_SPD:    reg_rdata_q <= rotation_detect_speed;
        `SDSD_ADDR_SPD_LIMIT:  reg_rdata_q <= speed_limit_q;
        `SDSD_ADDR_STATUS:     reg_rdata_q <= {9'h000, ot_stop_q,
                                 servo_alarm_q, p_control_q, dyn_brake_q,
                                 free_run_q, pos_lock_q, servo_on_q};
        `SDSD_ADDR_POWER:      reg_rdata_q <= {13'h0000, state_q};
        default:               reg_rdata_q <= 16'h0000;
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power sequence: filtered power_good, snapshot on power-up
  always @(posedge clk) begin
    if (rst) begin
      state_q       <= ST_OFF;
      pwr_cnt_q     <= 4'h0;
      act_one_q     <= `SDSD_RST_SETUP_ONE;
      act_two_q     <= `SDSD_RST_SETUP_TWO;
      servo_alarm_q <= 1'b0;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (!power_good) begin
            pwr_cnt_q <= 4'h0;
          end else if (pwr_cnt_q == `SDSD_PWR_FILTER) begin
            act_one_q <= drive_setup_word_one;
            act_two_q <= drive_setup_word_two;
            state_q   <= ST_RUN;
          end else begin
            pwr_cnt_q <= pwr_cnt_q + 4'h1;
          end
        end
        ST_RUN: begin
          pwr_cnt_q <= 4'h0;
          if (!power_good) begin
            state_q <= ST_DIP;
          end
        end
        ST_DIP: begin
          // a long loss is a full power cycle; a short one is momentary
          if (power_good) begin
            state_q <= ST_RUN;
            if (!act_one_q[`SDSD_B_ALARM_AUTO]) begin
              servo_alarm_q <= 1'b1;
            end
          end else if (pwr_cnt_q == `SDSD_PWR_FILTER) begin
            state_q   <= ST_OFF;
            pwr_cnt_q <= 4'h0;
          end else begin
            pwr_cnt_q <= pwr_cnt_q + 4'h1;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold comparators
  sdsd_cmp #(.W(W)) u_rot (
    .clk     (clk),
    .rst     (rst),
    .value   (motor_speed),
    .thresh  (rotation_detect_speed),
    .above_q (rot_above)
  );
  sdsd_cmp #(.W(W)) u_trq (
    .clk     (clk),
    .rst     (rst),
    .value   (torque_cmd),
    .thresh  (pswitch_torque_threshold),
    .above_q (trq_above)
  );
  sdsd_cmp #(.W(W)) u_spd (
    .clk     (clk),
    .rst     (rst),
    .value   (speed_cmd),
    .thresh  (pswitch_speed_threshold),
    .above_q (spd_above)
  );
  sdsd_cmp #(.W(W)) u_acc (
    .clk     (clk),
    .rst     (rst),
    .value   (accel_cmd),
    .thresh  (pswitch_accel_threshold),
    .above_q (acc_above)
  );

  sdsd_spdlim #(.W(W)) u_lim (
    .clk      (clk),
    .rst      (rst),
    .enable   (torque_mode),
    .speed    (motor_speed),
    .limit    (speed_limit_q),
    .retard_q (retard)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequence qualification and stop policy
  always @(posedge clk) begin
    if (rst) begin
      servo_on_q                   <= 1'b0;
      sensor_on_q                  <= 1'b0;
      fwd_enable_q                 <= 1'b0;
      rev_enable_q                 <= 1'b0;
      rotation_or_limit_status_out <= 1'b0;
      dyn_brake_q                  <= 1'b0;
      free_run_q                   <= 1'b0;
      estop_torque_en_q            <= 1'b0;
      estop_torque_q               <= {W{1'b0}};
      pos_lock_q                   <= 1'b0;
      ctrl_mode_q                  <= MODE_SPEED;
      int_speed_sel_q              <= 2'h0;
      p_control_q                  <= 1'b0;
      absolute_encoder_select      <= 1'b0;
      torque_ff_en_q               <= 1'b0;
      retard_torque_q              <= {W{1'b0}};
      ot_stop_q                    <= 1'b0;
    end else begin
      servo_on_q <= (state_q == ST_RUN) && !servo_alarm_q && !ot_stop_q &&
                    (act_one_q[`SDSD_B_RUN_FORCE] | run_in);
      sensor_on_q <= act_one_q[`SDSD_B_SENSOR_FORCE] | sensor_on_in;
      fwd_enable_q <= act_one_q[`SDSD_B_FWD_PERMIT] | !forward_prohibit_input;
      rev_enable_q <= act_one_q[`SDSD_B_REV_PERMIT] | !reverse_prohibit_input;
      rotation_or_limit_status_out <= act_one_q[`SDSD_B_STAT_SEL] ?
                                      current_limit_hit : rot_above;
      ctrl_mode_q <= eff_mode;
      int_speed_sel_q <= int_spd ? mode_f : 2'h0;
      absolute_encoder_select <= act_one_q[`SDSD_B_ABS_ENC];
      torque_ff_en_q <= act_one_q[`SDSD_B_TFF];
      retard_torque_q <= retard;
      // overtravel turns the servo off in every mode unless bit 9 selects position lock
      ot_stop_q <= ot_hit && !act_one_q[`SDSD_B_OT_LOCK];
      pos_lock_q <= (ot_hit && motor_stopped &&
                     act_one_q[`SDSD_B_OT_LOCK]) ||
                    (eff_mode == MODE_LOCK && motor_stopped);
      // bit 8 ignored in torque modes
      estop_torque_en_q <= ot_hit && !torque_mode &&
                           act_one_q[`SDSD_B_OT_ESTOP];
      estop_torque_q    <= emergency_stop_torque_param;
      free_run_q <= (abnormal_stop || (ot_hit && (torque_mode ||
                     !act_one_q[`SDSD_B_OT_ESTOP]))) &&
                    act_one_q[`SDSD_B_FREE_RUN] && !motor_stopped;
      if (motor_stopped) begin
        if (act_one_q[`SDSD_B_FREE_RUN] &&
            (torque_mode || !act_one_q[`SDSD_B_OT_ESTOP])) begin
          dyn_brake_q <= 1'b0;
        end else begin
          dyn_brake_q <= act_one_q[`SDSD_B_BRAKE_HOLD] && !servo_on_q;
        end
      end else begin
        dyn_brake_q <= !servo_on_q && !act_one_q[`SDSD_B_FREE_RUN];
      end
      case (psw_f)
        PSW_TRQ: p_control_q <= !torque_mode && trq_above;
        PSW_SPD: p_control_q <= !torque_mode && spd_above;
        PSW_ACC: p_control_q <= !torque_mode && acc_above;
        default: p_control_q <= 1'b0;
      endcase
    end
  end
endmodule // sdsd_setup_decode

// >>> logic/sdsd_spdlim.v
`timescale 1ns/1ns
// retarding torque proportional to speed above the limit
module sdsd_spdlim #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         enable,
  input  wire [W-1:0] speed,
  input  wire [W-1:0] limit,
  output reg  [W-1:0] retard_q
);
  wire [W-1:0] excess;
  assign excess = speed - limit;
  // unity gain keeps it simple; the loop scales it later
  always @(posedge clk) begin
    if (rst) begin
      retard_q <= {W{1'b0}};
    end else if (enable && (speed > limit)) begin
      retard_q <= excess;
    end else begin
      retard_q <= {W{1'b0}};
    end
  end
endmodule // sdsd_spdlim

// >>> shared/sdsd_regs.vh
`ifndef SDSD_REGS_VH
`define SDSD_REGS_VH
// register offsets on the plain register port
`define SDSD_ADDR_SETUP_ONE   4'h0
`define SDSD_ADDR_SETUP_TWO   4'h1
`define SDSD_ADDR_ACTIVE_ONE  4'h2
`define SDSD_ADDR_ACTIVE_TWO  4'h3
`define SDSD_ADDR_ESTOP_TRQ   4'h4
`define SDSD_ADDR_PSW_TRQ     4'h5
`define SDSD_ADDR_PSW_SPD     4'h6
`define SDSD_ADDR_PSW_ACC     4'h7
`define SDSD_ADDR_ROT_SPD     4'h8
`define SDSD_ADDR_SPD_LIMIT   4'h9
`define SDSD_ADDR_STATUS      4'ha
`define SDSD_ADDR_POWER       4'hb
// setup word one fields
`define SDSD_B_RUN_FORCE      0
`define SDSD_B_SENSOR_FORCE   1
`define SDSD_B_FWD_PERMIT     2
`define SDSD_B_REV_PERMIT     3
`define SDSD_B_STAT_SEL       4
`define SDSD_B_ALARM_AUTO     5
`define SDSD_B_FREE_RUN       6
`define SDSD_B_BRAKE_HOLD     7
`define SDSD_B_OT_ESTOP       8
`define SDSD_B_OT_LOCK        9
`define SDSD_B_MODE_LO        10
`define SDSD_B_MODE_HI        11
`define SDSD_B_PSW_LO         12
`define SDSD_B_PSW_HI         13
`define SDSD_B_ABS_ENC        14
`define SDSD_B_TFF            15
// setup word two: internal speed control select
`define SDSD_B2_INT_SPEED     2
// reset values
`define SDSD_RST_SETUP_ONE    16'h30ec
`define SDSD_RST_SETUP_TWO    16'h0000
`define SDSD_RST_PSW_TRQ      16'h00c8
`define SDSD_RST_ROT_SPD      16'h0014
`define SDSD_RST_ESTOP_TRQ    16'h0000
`define SDSD_RST_SPD_LIMIT    16'h0bb8
// timing: power-good filter in cycles
`define SDSD_PWR_FILTER       4'h8
`endif

// >>> tb/sdsd_plant.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// motor and encoder stand-in: speed jumps to target, or coasts down
// by a fixed step so a stop spans a few dozen cycles
module sdsd_plant (
  input  wire        clk,
  input  wire        rst,
  input  wire        slow,
  input  wire [15:0] target,
  output reg  [15:0] motor_speed,
  output wire        motor_stopped
);
  // only the coast-down is ramped; spin-up is instant to keep runs short
  always @(posedge clk) begin
    if (rst)
      motor_speed <= 16'h0000;
    else if (!slow || motor_speed < target + 16'h0010)
      motor_speed <= target;
    else
      motor_speed <= motor_speed - 16'h0010;
  end
  assign motor_stopped = (motor_speed == 16'h0000);
endmodule // sdsd_plant

// >>> tb/sdsd_props.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// port-level checker for the setup decoder
module sdsd_props #(
  parameter W = 16
) (
  input wire         clk,
  input wire         rst,
  input wire [3:0]   reg_addr,
  input wire         reg_wr,
  input wire         reg_rd,
  input wire [15:0]  reg_rdata_q,
  input wire         run_in,
  input wire         sensor_on_in,
  input wire         forward_prohibit_input,
  input wire         reverse_prohibit_input,
  input wire         power_good,
  input wire         abnormal_stop,
  input wire         servo_on_q,
  input wire         sensor_on_q,
  input wire         fwd_enable_q,
  input wire         rev_enable_q,
  input wire         servo_alarm_q,
  input wire [1:0]   ctrl_mode_q,
  input wire         p_control_q,
  input wire [W-1:0] retard_torque_q
);
  reg  [3:0] pg_q;
  reg        rot_wr_q;
  reg        calm_q;
  wire       run_ok = (pg_q == 4'hf);
  ////////////////////////////////////////////////////////////////////////////
  // power-good run length; far past the load filter, so settings are settled
  always @(posedge clk) begin
    if (rst) begin
      pg_q     <= 4'h0;
      rot_wr_q <= 1'b0;
      calm_q   <= 1'b0;
    end else begin
      pg_q     <= !power_good ? 4'h0 : (run_ok ? pg_q : pg_q + 4'h1);
      rot_wr_q <= rot_wr_q | (reg_wr & (reg_addr == 4'h8));
      calm_q   <= run_in & ~forward_prohibit_input &
                  ~reverse_prohibit_input & ~abnormal_stop;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // mode held steady long enough for the two-stage compare paths
  sequence speed_run3;
    (run_ok && !ctrl_mode_q[1]) [*3];
  endsequence
  sequence torque_run3;
    (run_ok && ctrl_mode_q[1]) [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_rd: assert property (reg_rd && reg_addr > 4'hb
    |=> reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
  a_rot_default: assert property (
    reg_rd && reg_addr == 4'h8 && !rot_wr_q |=> reg_rdata_q == 16'h0014)
    else $error("rotation threshold default wrong");
  a_servo_run: assert property (
    run_ok && calm_q && $past(calm_q) && !servo_alarm_q |-> servo_on_q)
    else $error("servo off with run request");
  a_sensor_pass: assert property (
    run_ok && $past(sensor_on_in) |-> sensor_on_q)
    else $error("sensor input lost");
  a_fwd_permit: assert property (
    run_ok && !$past(forward_prohibit_input) |-> fwd_enable_q)
    else $error("forward blocked without prohibit");
  a_rev_permit: assert property (
    run_ok && !$past(reverse_prohibit_input) |-> rev_enable_q)
    else $error("reverse blocked without prohibit");
  a_alarm_sticky: assert property (servo_alarm_q |=> servo_alarm_q)
    else $error("alarm cleared without reset");
  a_pctl_torque: assert property (torque_run3 |-> !p_control_q)
    else $error("p switching in torque mode");
  a_retard_speed: assert property (
    speed_run3 |-> retard_torque_q == {W{1'b0}})
    else $error("retard torque in speed mode");
endmodule // sdsd_props

bind sdsd_setup_decode sdsd_props #(.W(W)) u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .run_in(run_in),
  .sensor_on_in(sensor_on_in),
  .forward_prohibit_input(forward_prohibit_input),
  .reverse_prohibit_input(reverse_prohibit_input),
  .power_good(power_good), .abnormal_stop(abnormal_stop),
  .servo_on_q(servo_on_q), .sensor_on_q(sensor_on_q),
  .fwd_enable_q(fwd_enable_q), .rev_enable_q(rev_enable_q),
  .servo_alarm_q(servo_alarm_q), .ctrl_mode_q(ctrl_mode_q),
  .p_control_q(p_control_q), .retard_torque_q(retard_torque_q));

// >>> tb/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; \
  if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, (e), (g)); end end
////////////////////////////////////////////////////////////////////////////
module tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         run_in = 1'b0;
  reg         sensor_on_in = 1'b0;
  reg         fp = 1'b0;
  reg         rp = 1'b0;
  reg         power_good = 1'b0;
  reg         abnormal_stop = 1'b0;
  reg         clim = 1'b0;
  reg         slow = 1'b0;
  reg  [15:0] tgt = 16'h0000;
  reg  [15:0] torque_cmd = 16'h0000;
  reg  [15:0] speed_cmd = 16'h0000;
  reg  [15:0] accel_cmd = 16'h0000;
  wire [15:0] motor_speed, rdata, retard, etrq;
  wire [1:0]  mode, isel;
  wire        motor_stopped, servo, sensor, fwd, rev, stat, alarm;
  wire        dyn, free, pctl, abs_enc, tff, plock, eten;
  int         bad_count = 0, checks_done = 0, cycles = 0, i, j, k;
  reg  [31:0] v;
  reg  [15:0] w, w2, rv, e;
  reg         ot, pe;
  reg  [1:0]  m;
  reg  [15:0] spd_tab [4] = '{16'h0000, 16'h0014, 16'h0015, 16'h0c1c};
  reg  [15:0] cmd_tab [4] = '{16'h0000, 16'h00c8, 16'h00c9, 16'h0bb8};
  reg  [3:0]  ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc};
  reg  [15:0] rx [9] = '{16'h30ec, 16'h0000, 16'h30ec, 16'h0000, 16'h0000,
                         16'h00c8, 16'h0014, 16'h0bb8, 16'h0000};
  reg  [15:0] bw [5] = '{16'h0080, 16'h0000, 16'h00c0, 16'h01c0, 16'h0dc0};
  reg         bx [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  sdsd_setup_decode #(.W(16)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .run_in(run_in),
    .sensor_on_in(sensor_on_in), .forward_prohibit_input(fp),
    .reverse_prohibit_input(rp), .power_good(power_good),
    .abnormal_stop(abnormal_stop), .motor_speed(motor_speed),
    .speed_cmd(speed_cmd), .torque_cmd(torque_cmd), .accel_cmd(accel_cmd),
    .current_limit_hit(clim), .motor_stopped(motor_stopped),
    .servo_on_q(servo), .sensor_on_q(sensor), .fwd_enable_q(fwd),
    .rev_enable_q(rev), .rotation_or_limit_status_out(stat),
    .servo_alarm_q(alarm), .dyn_brake_q(dyn), .free_run_q(free),
    .estop_torque_en_q(eten), .estop_torque_q(etrq), .pos_lock_q(plock),
    .ctrl_mode_q(mode), .int_speed_sel_q(isel), .p_control_q(pctl),
    .absolute_encoder_select(abs_enc), .torque_ff_en_q(tff),
    .retard_torque_q(retard));
  sdsd_plant u_plant (.clk(clk), .rst(rst), .slow(slow), .target(tgt),
    .motor_speed(motor_speed), .motor_stopped(motor_stopped));

  always #2 clk = ~clk;
  // hang guard; the whole run needs fewer than two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // setup words only take hold across a full power cycle
  task apply(input [15:0] a, input [15:0] b);
    wr(4'h0, a);
    wr(4'h1, b);
    @(posedge clk);
    power_good <= 1'b0;
    // power stays off long enough to clear
    cyc(14);
    power_good <= 1'b1;
    cyc(16);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'hd32d);
    cyc(3);
    rst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      rd(ra[i]);
      `CHK("reg", rx[i], rv)
    end
    wr(4'h2, 16'h1234);
    rd(4'h2);
    `CHK("applied_ro", 16'h30ec, rv)
    wr(4'h0, 16'h4001);
    rd(4'h2);
    `CHK("applied_early", 16'h30ec, rv)
    @(posedge clk);
    power_good <= 1'b1;
    cyc(16);
    rd(4'h2);
    `CHK("applied_late", 16'h4001, rv)
    $display("test registers done");
    wr(4'h6, 16'h00c8);
    wr(4'h7, 16'h00c8);
    wr(4'h4, 16'h0123);
    // every mode and switch condition, random other bits and inputs
    for (i = 0; i < 16; i++) begin
      v = $urandom;
      w = {v[15:14], i[3:0], v[9:0]};
      w2 = {13'h0000, v[16] & ~i[1], 2'h0};
      apply(w, w2);
      m = w2[2] ? 2'h0 : w[11:10];
      for (j = 0; j < 6; j++) begin
        v = $urandom;
        @(posedge clk);
        run_in <= v[0];
        sensor_on_in <= v[1];
        fp <= v[2] & v[3];
        rp <= v[4] & v[5];
        clim <= v[6];
        tgt <= spd_tab[v[9:8]];
        torque_cmd <= cmd_tab[v[11:10]];
        speed_cmd <= cmd_tab[v[13:12]];
        accel_cmd <= cmd_tab[v[15:14]];
        cyc(5);
        #1 ot = (fp & ~w[2]) | (rp & ~w[3]);
        pe = (w[13:12] == 2'h0) ? torque_cmd > 16'h00c8 :
             (w[13:12] == 2'h1) ? speed_cmd > 16'h00c8 :
             (w[13:12] == 2'h2) ? accel_cmd > 16'h00c8 : 1'b0;
        e = (m[1] && tgt > 16'h0bb8) ? tgt - 16'h0bb8 : 16'h0000;
        `CHK("servo", (w[0] | run_in) & ~(ot & ~w[9]), servo)
        if (m != 2'h1)
          `CHK("pos_lock", ot & (tgt == 16'h0000) & w[9], plock)
        `CHK("estop_en", ot & ~m[1] & w[8], eten)
        `CHK("estop_trq", 16'h0123, etrq)
        `CHK("sensor", w[1] | sensor_on_in, sensor)
        `CHK("fwd", w[2] | ~fp, fwd)
        `CHK("rev", w[3] | ~rp, rev)
        `CHK("status", w[4] ? clim : tgt > 16'h0014, stat)
        `CHK("mode", m, mode)
        `CHK("int_speed", w2[2] ? w[11:10] : 2'h0, isel)
        `CHK("abs_enc", w[14], abs_enc)
        `CHK("tff", w[15], tff)
        `CHK("pctl", pe & ~m[1], pctl)
        `CHK("retard", e, retard)
      end
    end
    $display("test decode sweep done");
    // short dip: alarm only when auto-clear is off
    for (k = 0; k < 2; k++) begin
      apply(k ? 16'h0000 : 16'h0020, 16'h0000);
      @(posedge clk);
      power_good <= 1'b0;
      cyc(3);
      power_good <= 1'b1;
      cyc(16);
      #1 `CHK("alarm", k[0], alarm)
    end
    @(posedge clk);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    #1 `CHK("alarm_rst", 1'b0, alarm)
    $display("test power dip done");
    // abnormal stop while coasting, then brake state once stopped
    for (k = 0; k < 5; k++) begin
      apply(bw[k], 16'h0000);
      @(posedge clk);
      run_in <= 1'b0;
      tgt <= 16'h01f4;
      cyc(4);
      slow <= 1'b1;
      tgt <= 16'h0000;
      abnormal_stop <= 1'b1;
      cyc(4);
      #1 `CHK("free", bw[k][6], free)
      `CHK("dyn_moving", ~bw[k][6], dyn)
      cyc(60);
      #1 `CHK("dyn_stop", bx[k], dyn)
      @(posedge clk);
      abnormal_stop <= 1'b0;
      slow <= 1'b0;
    end
    $display("test brake done");
    conclude;
  end
endmodule // tb
